// file: pgdc_top.sv
`default_nettype none
// How it works
// - Index low four bits pick the indexed register on the data port.
// - Each plane fill value bit is replicated across the whole written byte.
// - Fill enable bit one gives 00 or ff per plane in write modes 0 and 2; zero disables it there.
// - Filled byte still goes through the logic function and bit mask.
// - Without fill, data comes from write mode, CPU data and mask.
// - Fill has no effect in write mode 1.
// - Compare read gives a one per pixel whose four plane bits match.
// - Function field: move, AND, OR, XOR with the latch.
// - Masked-off bits always write the latch value.
// - Logic function applies in write modes 0, 2, 3, not 1.
// - Rotate count turns CPU data right circularly by zero to seven.
// - Read plane field chooses the plane returned on a normal read.
// - Mode bit 6 selects 256-colour shift loading, else bit 5 decides.
// - Odd/even reads take the pair's even plane on A0 zero, else odd.
// - Read mode bit selects plane byte or compare result.
// - Write mode 0 sends rotated byte to every plane, fill overriding.
// - Write mode 1 writes latches unmodified, ignoring bit mask.
// - Write mode 2 widens CPU bits 0..3 to plane bytes, no rotation.
// - Write mode 3 writes fill pattern, mask is rotated data AND mask.
module pgdc_top #(
  parameter int PLANES = 4
) (
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RST_N_I,
  // Register port, same clock domain
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic                REG_SEL_DATA_I,
  input  wire logic [7:0]          REG_WDATA_I,
  output logic      [7:0]          REG_RDATA_O,
  // CPU memory access
  input  wire logic                MEM_WR_I,
  input  wire logic                MEM_RD_I,
  input  wire logic                ADDR0_I,
  input  wire logic [7:0]          CPU_WDATA_I,
  output logic      [7:0]          CPU_RDATA_O,
  // Display memory planes
  input  wire logic [PLANES*8-1:0] PLANE_RDATA_I,
  output logic      [PLANES*8-1:0] PLANE_WDATA_O,
  output logic      [PLANES-1:0]   PLANE_WE_O,
  // Shift loading controls for the attribute controller
  output logic                     SHIFT_256_O,
  output logic                     SHIFT_ALT_O
);
  logic [3:0]          index;
  logic [7:0]          plane_fill_value;
  logic [7:0]          plane_fill_enable;
  logic [7:0]          pixel_match_value;
  logic [7:0]          rotate_and_logic_select;
  logic [7:0]          read_plane_choice;
  logic [7:0]          datapath_mode;
  logic [7:0]          bit_mask;
  logic [7:0]          latch [PLANES];
  logic [7:0]          rot_data;
  logic [7:0]          reg_view;
  logic [7:0]          match_bits;
  logic [1:0]          plane_sel;
  logic [7:0]          next_cpu_rdata;
  logic [PLANES*8-1:0] lane_wdata;
  logic [2:0]          rot;
  logic [1:0]          wmode;
  logic [1:0]          func;
  // Per-register write strobes from the data port decode.
  logic                wr_fill_value;
  logic                wr_fill_enable;
  logic                wr_match_value;
  logic                wr_rotate_fn;
  logic                wr_read_plane;
  logic                wr_mode;
  logic                wr_bit_mask;

  assign rot   = rotate_and_logic_select[pgdc_pkg::ROT_LSB +: 3];
  assign wmode = datapath_mode[pgdc_pkg::MODE_WM_LSB +: 2];
  assign func  = rotate_and_logic_select[pgdc_pkg::FN_LSB +: 2];

  // Index register, reached when the data select is low.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      index <= 4'h0;
    else if (REG_WR_I && !REG_SEL_DATA_I)
      index <= REG_WDATA_I[3:0];
  end

  // Data port decode: one strobe per implemented index, none for the rest.
  always_comb
  begin
    wr_fill_value  = 1'b0;
    wr_fill_enable = 1'b0;
    wr_match_value = 1'b0;
    wr_rotate_fn   = 1'b0;
    wr_read_plane  = 1'b0;
    wr_mode        = 1'b0;
    wr_bit_mask    = 1'b0;
    if (REG_WR_I && REG_SEL_DATA_I)
    begin
      if (index == pgdc_pkg::IDX_FILL_VALUE)
        wr_fill_value = 1'b1;
      else if (index == pgdc_pkg::IDX_FILL_ENABLE)
        wr_fill_enable = 1'b1;
      else if (index == pgdc_pkg::IDX_MATCH_VALUE)
        wr_match_value = 1'b1;
      else if (index == pgdc_pkg::IDX_ROTATE_FN)
        wr_rotate_fn = 1'b1;
      else if (index == pgdc_pkg::IDX_READ_PLANE)
        wr_read_plane = 1'b1;
      else if (index == pgdc_pkg::IDX_MODE)
        wr_mode = 1'b1;
      else if (index == pgdc_pkg::IDX_BIT_MASK)
        wr_bit_mask = 1'b1;
    end
  end

  // Indexed registers; reserved bits are masked on entry so they read as zero.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      plane_fill_value <= pgdc_pkg::RST_ZERO;
    else if (wr_fill_value)
      plane_fill_value <= REG_WDATA_I & pgdc_pkg::MASK_NIBBLE;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      plane_fill_enable <= pgdc_pkg::RST_ZERO;
    else if (wr_fill_enable)
      plane_fill_enable <= REG_WDATA_I & pgdc_pkg::MASK_NIBBLE;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      pixel_match_value <= pgdc_pkg::RST_ZERO;
    else if (wr_match_value)
      pixel_match_value <= REG_WDATA_I & pgdc_pkg::MASK_NIBBLE;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      rotate_and_logic_select <= pgdc_pkg::RST_ZERO;
    else if (wr_rotate_fn)
      rotate_and_logic_select <= REG_WDATA_I & pgdc_pkg::MASK_ROT_FN;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      read_plane_choice <= pgdc_pkg::RST_ZERO;
    else if (wr_read_plane)
      read_plane_choice <= REG_WDATA_I & pgdc_pkg::MASK_PLANE;
  end

  // Bit 5 is kept although reserved, because it steers the shift loading.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      datapath_mode <= pgdc_pkg::RST_ZERO;
    else if (wr_mode)
      datapath_mode <= REG_WDATA_I & pgdc_pkg::MASK_MODE;
  end

  // The mask resets to all ones so that early writes are not silently dropped.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      bit_mask <= pgdc_pkg::RST_BIT_MASK;
    else if (wr_bit_mask)
      bit_mask <= REG_WDATA_I;
  end

  // Register read-back; unimplemented indices read as zero.
  always_comb
  begin
    reg_view = 8'h00;
    if (!REG_SEL_DATA_I)
      reg_view = {4'h0, index};
    else if (index == pgdc_pkg::IDX_FILL_VALUE)
      reg_view = plane_fill_value;
    else if (index == pgdc_pkg::IDX_FILL_ENABLE)
      reg_view = plane_fill_enable;
    else if (index == pgdc_pkg::IDX_MATCH_VALUE)
      reg_view = pixel_match_value;
    else if (index == pgdc_pkg::IDX_ROTATE_FN)
      reg_view = rotate_and_logic_select;
    else if (index == pgdc_pkg::IDX_READ_PLANE)
      reg_view = read_plane_choice;
    else if (index == pgdc_pkg::IDX_MODE)
      reg_view = datapath_mode;
    else if (index == pgdc_pkg::IDX_BIT_MASK)
      reg_view = bit_mask;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      REG_RDATA_O <= 8'h00;
    else if (REG_RD_I)
      REG_RDATA_O <= reg_view;
  end

  // Circular right rotation; doubling the byte avoids a variable-width wrap.
  always_comb
  begin
    logic [15:0] dbl;
    dbl      = {CPU_WDATA_I, CPU_WDATA_I} >> rot;
    rot_data = dbl[7:0];
  end

  // Pixel compare: bit b matches when every plane's bit b equals the colour.
  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      match_bits[b] = 1'b1;
      for (int p = 0; p < PLANES; p++)
      begin
        if (PLANE_RDATA_I[p*8+b] != pixel_match_value[p])
          match_bits[b] = 1'b0;
      end
    end
  end

  // Odd/even mode replaces the plane's low bit with address bit 0.
  always_comb
  begin
    plane_sel = read_plane_choice[1:0];
    if (datapath_mode[pgdc_pkg::MODE_OE_BIT])
      plane_sel = {read_plane_choice[1], ADDR0_I};
  end

  // The compare result takes the place of the plane byte in read mode 1.
  always_comb
  begin
    if (datapath_mode[pgdc_pkg::MODE_RM_BIT])
      next_cpu_rdata = match_bits;
    else
      next_cpu_rdata = PLANE_RDATA_I[plane_sel*8 +: 8];
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      CPU_RDATA_O <= 8'h00;
    else if (MEM_RD_I)
      CPU_RDATA_O <= next_cpu_rdata;
  end

  // Plane latches and write lanes.
  genvar g;
  generate
    for (g = 0; g < PLANES; g++)
    begin : g_plane
      always_ff @(posedge CLK_I)
      begin
        if (!RST_N_I)
          latch[g] <= 8'h00;
        else if (MEM_RD_I)
          latch[g] <= PLANE_RDATA_I[g*8 +: 8];
      end

      pgdc_plane_lane u_lane (
        .wmode_i    (wmode),
        .func_i     (func),
        .fill_en_i  (plane_fill_enable[g]),
        .fill_val_i (plane_fill_value[g]),
        .cpu_bit_i  (CPU_WDATA_I[g]),
        .rot_data_i (rot_data),
        .mask_i     (bit_mask),
        .latch_i    (latch[g]),
        .wdata_o    (lane_wdata[g*8 +: 8])
      );
    end
  endgenerate

  // Write strobes are registered so memory sees them one cycle after MEM_WR_I.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      PLANE_WE_O <= '0;
    else
      PLANE_WE_O <= {PLANES{MEM_WR_I}};
  end

  // Write data holds between writes, so memory may sample it late.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      PLANE_WDATA_O <= '0;
    else if (MEM_WR_I)
      PLANE_WDATA_O <= lane_wdata;
  end

  assign SHIFT_256_O = datapath_mode[pgdc_pkg::MODE_256_BIT];
  assign SHIFT_ALT_O = !datapath_mode[pgdc_pkg::MODE_256_BIT] &&
                       datapath_mode[pgdc_pkg::MODE_SH_BIT];
endmodule
`default_nettype wire

// file: pgdc_pkg.sv
`default_nettype none
package pgdc_pkg;
  // Indexed register numbers reached through the shared data port.
  localparam logic [3:0] IDX_FILL_VALUE  = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
  localparam logic [3:0] IDX_MATCH_VALUE = 4'h2;
  localparam logic [3:0] IDX_ROTATE_FN   = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE  = 4'h4;
  localparam logic [3:0] IDX_MODE        = 4'h5;
  localparam logic [3:0] IDX_BIT_MASK    = 4'h8;
  // Field positions.
  localparam int ROT_LSB     = 0;
  localparam int FN_LSB      = 3;
  localparam int MODE_WM_LSB = 0;
  localparam int MODE_RM_BIT = 3;
  localparam int MODE_OE_BIT = 4;
  localparam int MODE_SH_BIT = 5;
  localparam int MODE_256_BIT = 6;
  // Writable bits per register; others read as zero.
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_ROT_FN = 8'h1f;
  localparam logic [7:0] MASK_PLANE  = 8'h03;
  localparam logic [7:0] MASK_MODE   = 8'h7b;
  // Reset values.
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_BIT_MASK = 8'hff;
  typedef enum logic [1:0] {
    PGDC_WM0 = 2'b00,
    PGDC_WM1 = 2'b01,
    PGDC_WM2 = 2'b10,
    PGDC_WM3 = 2'b11
  } pgdc_wmode_t;
  typedef enum logic [1:0] {
    PGDC_FN_MOVE = 2'b00,
    PGDC_FN_AND  = 2'b01,
    PGDC_FN_OR   = 2'b10,
    PGDC_FN_XOR  = 2'b11
  } pgdc_func_t;
endpackage
`default_nettype wire

// file: pgdc_plane_lane.sv
`default_nettype none
// One plane's write path: source select, latch combiner and bit mask.
module pgdc_plane_lane (
  // Controls
  input  wire logic [1:0] wmode_i,
  input  wire logic [1:0] func_i,
  input  wire logic       fill_en_i,
  input  wire logic       fill_val_i,
  input  wire logic       cpu_bit_i,
  // Data
  input  wire logic [7:0] rot_data_i,
  input  wire logic [7:0] mask_i,
  input  wire logic [7:0] latch_i,
  output logic      [7:0] wdata_o
);
  logic [7:0] src;
  logic [7:0] comb;
  logic [7:0] eff_mask;

  always_comb
  begin
    src      = rot_data_i;
    eff_mask = mask_i;
    case (wmode_i)
      pgdc_pkg::PGDC_WM0:
      begin
        src = fill_en_i ? {8{fill_val_i}} : rot_data_i;
      end
      pgdc_pkg::PGDC_WM2:
      begin
        // Rotation is bypassed here because only one CPU bit feeds the plane.
        src = fill_en_i ? {8{fill_val_i}} : {8{cpu_bit_i}};
      end
      pgdc_pkg::PGDC_WM3:
      begin
        src      = {8{fill_val_i}};
        eff_mask = rot_data_i & mask_i;
      end
      default:
      begin
        src      = latch_i;
        eff_mask = 8'h00;
      end
    endcase
    case (func_i)
      pgdc_pkg::PGDC_FN_AND: comb = src & latch_i;
      pgdc_pkg::PGDC_FN_OR:  comb = src | latch_i;
      pgdc_pkg::PGDC_FN_XOR: comb = src ^ latch_i;
      default:               comb = src;
    endcase
    // Write mode 1 forces the mask to zero so the function never reaches memory.
    wdata_o = (comb & eff_mask) | (latch_i & ~eff_mask);
  end
endmodule
`default_nettype wire

// file: pgdc_mem_model.sv
`default_nettype none
// Four planes, each holding only the addressed byte of display memory.
module pgdc_mem_model (
  // Clock
  input  wire logic        clk_i,
  // Bench preload
  input  wire logic        load_i,
  input  wire logic [31:0] load_data_i,
  // Plane port
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  we_i,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i)
  begin
    if (load_i)
      rdata_o <= load_data_i;
    else
      for (int p = 0; p < 4; p++)
        if (we_i[p])
          rdata_o[8*p +: 8] <= wdata_i[8*p +: 8];
  end
endmodule
`default_nettype wire

// file: pgdc_top_properties.sv
`default_nettype none
module pgdc_top_properties #(
  parameter int PLANES = 4
) (
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RST_N_I,
  // Register port
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic                REG_SEL_DATA_I,
  input  wire logic [7:0]          REG_WDATA_I,
  input  wire logic [7:0]          REG_RDATA_O,
  // Memory side
  input  wire logic                MEM_WR_I,
  input  wire logic                MEM_RD_I,
  input  wire logic                ADDR0_I,
  input  wire logic [7:0]          CPU_RDATA_O,
  input  wire logic [PLANES*8-1:0] PLANE_RDATA_I,
  input  wire logic [PLANES*8-1:0] PLANE_WDATA_O,
  input  wire logic [PLANES-1:0]   PLANE_WE_O,
  input  wire logic                SHIFT_256_O,
  input  wire logic                SHIFT_ALT_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]          idx;
  logic [7:0]          mode;
  logic [7:0]          rsel;
  logic [PLANES*8-1:0] lat;
  // Shadow registers rebuilt from port traffic, so no internal name is needed.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      idx <= 4'h0;
      mode <= 8'h00;
      rsel <= 8'h00;
    end
    else if (REG_WR_I && !REG_SEL_DATA_I)
      idx <= REG_WDATA_I[3:0];
    else if (REG_WR_I && idx == pgdc_pkg::IDX_MODE)
      mode <= REG_WDATA_I & pgdc_pkg::MASK_MODE;
    else if (REG_WR_I && idx == pgdc_pkg::IDX_READ_PLANE)
      rsel <= REG_WDATA_I;
  end
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      lat <= '0;
    else if (MEM_RD_I)
      lat <= PLANE_RDATA_I;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_write_all_planes:
    assert property (MEM_WR_I |=> PLANE_WE_O == 4'hf) else $error("planes not strobed");
  a_strobe_one_cycle:
    assert property (!MEM_WR_I |=> PLANE_WE_O == 4'h0) else $error("stray plane strobe");
  a_wdata_holds:
    assert property (!MEM_WR_I |=> $stable(PLANE_WDATA_O)) else $error("write data moved");
  a_mode1_latch_copy:
    assert property (MEM_WR_I && mode[1:0] == 2'b01 |=> PLANE_WDATA_O == $past(lat))
      else $error("mode 1 did not copy latches");
  a_plane_read_select:
    assert property (MEM_RD_I && !mode[3] && !mode[4] |=>
      CPU_RDATA_O == 8'($past(PLANE_RDATA_I) >> {$past(rsel[1:0]), 3'b000}))
      else $error("wrong plane read");
  a_odd_even_read:
    assert property (MEM_RD_I && !mode[3] && mode[4] |=>
      CPU_RDATA_O == 8'($past(PLANE_RDATA_I) >> {$past(rsel[1]), $past(ADDR0_I), 3'b000}))
      else $error("wrong odd/even plane");
  a_read_data_holds:
    assert property (!MEM_RD_I |=> $stable(CPU_RDATA_O)) else $error("read data moved");
  a_reg_data_holds:
    assert property (!REG_RD_I |=> $stable(REG_RDATA_O)) else $error("register data moved");
  a_shift_controls:
    assert property (SHIFT_256_O == mode[6] && SHIFT_ALT_O == (mode[5] && !mode[6]))
      else $error("shift controls wrong");
endmodule
bind pgdc_top pgdc_top_properties #(.PLANES(PLANES)) u_prop (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_SEL_DATA_I(REG_SEL_DATA_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .MEM_WR_I(MEM_WR_I), .MEM_RD_I(MEM_RD_I), .ADDR0_I(ADDR0_I), .CPU_RDATA_O(CPU_RDATA_O),
  .PLANE_RDATA_I(PLANE_RDATA_I), .PLANE_WDATA_O(PLANE_WDATA_O), .PLANE_WE_O(PLANE_WE_O),
  .SHIFT_256_O(SHIFT_256_O), .SHIFT_ALT_O(SHIFT_ALT_O));
`default_nettype wire

// file: tb_planar_graphics_data_controller.sv
`default_nettype none
module tb_planar_graphics_data_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PAT = 32'h3ca50f96;
  logic CLK_I = 0, RST_N_I = 0, REG_WR_I = 0, REG_RD_I = 0, REG_SEL_DATA_I = 0;
  logic MEM_WR_I = 0, MEM_RD_I = 0, ADDR0_I = 0, load = 0, SHIFT_256_O, SHIFT_ALT_O;
  logic [7:0] REG_WDATA_I = 8'h00, CPU_WDATA_I = 8'h00, REG_RDATA_O, CPU_RDATA_O;
  logic [31:0] PLANE_RDATA_I, PLANE_WDATA_O, load_data = 32'h0;
  logic [3:0] PLANE_WE_O;
  int num_errors = 0, n_tests = 0;
  pgdc_top u_dut (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_SEL_DATA_I(REG_SEL_DATA_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .MEM_WR_I(MEM_WR_I), .MEM_RD_I(MEM_RD_I), .ADDR0_I(ADDR0_I), .CPU_WDATA_I(CPU_WDATA_I),
    .CPU_RDATA_O(CPU_RDATA_O), .PLANE_RDATA_I(PLANE_RDATA_I),
    .PLANE_WDATA_O(PLANE_WDATA_O), .PLANE_WE_O(PLANE_WE_O),
    .SHIFT_256_O(SHIFT_256_O), .SHIFT_ALT_O(SHIFT_ALT_O));
  pgdc_mem_model u_mem (.clk_i(CLK_I), .load_i(load), .load_data_i(load_data),
    .wdata_i(PLANE_WDATA_O), .we_i(PLANE_WE_O), .rdata_o(PLANE_RDATA_I));
  initial forever #50 CLK_I = ~CLK_I;
  task automatic tick();
    @(posedge CLK_I);
    #10;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
    REG_WR_I = 1;
    REG_SEL_DATA_I = 0;
    REG_WDATA_I = {4'h0, idx};
    tick();
    REG_SEL_DATA_I = 1;
    REG_WDATA_I = val;
    tick();
    REG_WR_I = 0;
    tick();
  endtask
  task automatic rd_reg(input logic [3:0] idx, input logic [7:0] exp);
    REG_WR_I = 1;
    REG_SEL_DATA_I = 0;
    REG_WDATA_I = {4'h0, idx};
    tick();
    REG_WR_I = 0;
    REG_RD_I = 1;
    REG_SEL_DATA_I = 1;
    tick();
    REG_RD_I = 0;
    cmp8(REG_RDATA_O, exp);
  endtask
  task automatic mem_rd(input logic a0);
    ADDR0_I = a0;
    MEM_RD_I = 1;
    tick();
    MEM_RD_I = 0;
    tick();
  endtask
  task automatic fill_mem();
    load = 1;
    load_data = PAT;
    tick();
    load = 0;
    tick();
  endtask
  task automatic do_write(input logic [1:0] wm, fn, input logic [2:0] rot,
                          input logic [3:0] en, val, input logic [7:0] bm, cpu);
    logic [7:0] rd, src, m, f, l;
    wr_reg(pgdc_pkg::IDX_FILL_VALUE, {4'h0, val});
    wr_reg(pgdc_pkg::IDX_FILL_ENABLE, {4'h0, en});
    wr_reg(pgdc_pkg::IDX_ROTATE_FN, {3'h0, fn, rot});
    wr_reg(pgdc_pkg::IDX_MODE, {6'h00, wm});
    wr_reg(pgdc_pkg::IDX_BIT_MASK, bm);
    fill_mem();
    mem_rd(1'b0);
    MEM_WR_I = 1;
    CPU_WDATA_I = cpu;
    tick();
    MEM_WR_I = 0;
    cmp8({4'h0, PLANE_WE_O}, 8'h0f);
    rd = (cpu >> rot) | (cpu << (8 - rot));
    for (int p = 0; p < 4; p++)
    begin
      l = PAT[8*p +: 8];
      src = (wm == 2'b10) ? {8{cpu[p]}} : rd;
      if (wm == 2'b11 || (en[p] && wm != 2'b01))
        src = {8{val[p]}};
      m = (wm == 2'b11) ? (rd & bm) : (wm == 2'b01) ? 8'h00 : bm;
      f = (fn == 2'b01) ? src & l : (fn == 2'b10) ? src | l : (fn == 2'b11) ? src ^ l : src;
      cmp8(PLANE_WDATA_O[8*p +: 8], (f & m) | (l & ~m));
    end
  endtask
  task automatic t_regs();
    logic [3:0] ix [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
    logic [7:0] mk [8] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'hff, 8'h00};
    for (int i = 0; i < 8; i++)
      rd_reg(ix[i], (i == 6) ? 8'hff : 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(ix[i], 8'hff);
      rd_reg(ix[i], mk[i]);
    end
    tick();
    REG_RD_I = 1;
    REG_SEL_DATA_I = 0;
    tick();
    REG_RD_I = 0;
    cmp8(REG_RDATA_O, 8'h09);
  endtask
  task automatic t_writes();
    for (int fn = 0; fn < 4; fn++)
      do_write(2'b00, 2'(fn), 3'd3, 4'h0, 4'h0, 8'hf0, 8'h81);
    do_write(2'b00, 2'b11, 3'd1, 4'h5, 4'h3, 8'h3c, 8'h5a);
    do_write(2'b01, 2'b11, 3'd2, 4'hf, 4'h9, 8'h0f, 8'h77);
    do_write(2'b10, 2'b10, 3'd5, 4'h2, 4'h2, 8'hc3, 8'h0d);
    do_write(2'b11, 2'b01, 3'd4, 4'h0, 4'ha, 8'h7e, 8'h96);
  endtask
  task automatic t_reads();
    logic [7:0] exp;
    fill_mem();
    wr_reg(pgdc_pkg::IDX_MODE, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(pgdc_pkg::IDX_READ_PLANE, 8'(p));
      mem_rd(1'b1);
      cmp8(CPU_RDATA_O, PAT[8*p +: 8]);
    end
    wr_reg(pgdc_pkg::IDX_MODE, 8'h10);
    mem_rd(1'b0);
    cmp8(CPU_RDATA_O, PAT[23:16]);
    mem_rd(1'b1);
    cmp8(CPU_RDATA_O, PAT[31:24]);
    wr_reg(pgdc_pkg::IDX_MODE, 8'h08);
    wr_reg(pgdc_pkg::IDX_MATCH_VALUE, 8'h06);
    mem_rd(1'b0);
    for (int i = 0; i < 8; i++)
      exp[i] = {PAT[24+i], PAT[16+i], PAT[8+i], PAT[i]} == 4'h6;
    cmp8(CPU_RDATA_O, exp);
    wr_reg(pgdc_pkg::IDX_MODE, 8'h60);
    cmp8({6'h00, SHIFT_256_O, SHIFT_ALT_O}, 8'h02);
    wr_reg(pgdc_pkg::IDX_MODE, 8'h20);
    cmp8({6'h00, SHIFT_256_O, SHIFT_ALT_O}, 8'h01);
  endtask
  task automatic wrap_up();
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge CLK_I);
    #10;
    RST_N_I = 1;
    t_regs();
    t_writes();
    t_reads();
    wrap_up();
  end
  // The whole run needs well under a thousand cycles.
  initial
  begin
    #500000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
